// [include/cwmg_consts.svh]
// Offsets, field positions, reset values and encodings of the configuration word guard
`ifndef CWMG_CONSTS_SVH
`define CWMG_CONSTS_SVH

`define CWMG_WORD_W 14
`define CWMG_WORD_BLANK 14'h3fff
`define CWMG_LVE_BIT 13
`define CWMG_SCAV_BIT 12
`define CWMG_SWG_LSB 0
`define CWMG_EEL_BIT 1
`define CWMG_PRL_BIT 0
`define CWMG_MEMCFG_UNIMPL 14'h0ffc
`define CWMG_CODEPROT_UNIMPL 14'h3ffc

`define CWMG_SWG_OFF 2'h3
`define CWMG_SWG_BOOT 2'h2
`define CWMG_SWG_HALF 2'h1
`define CWMG_SWG_ALL 2'h0
`define CWMG_SWG_BOOT_LAST 15'h01ff
`define CWMG_SWG_HALF_LAST 15'h1fff
`define CWMG_PROG_LAST 15'h3fff

`define CWMG_REG_MEMCFG 4'h0
`define CWMG_REG_CODEPROT 4'h1
`define CWMG_REG_STATUS 4'h2
`define CWMG_REG_CTRL 4'h3
`define CWMG_REG_REFCNT 4'h4

`define CWMG_ST_LOADED 0
`define CWMG_ST_PROG_LOW 1
`define CWMG_ST_PROG_HIGH 2
`define CWMG_ST_EXT_REF 3
`define CWMG_ST_SELF_REF 4
`define CWMG_ST_LVE_REF 5
`define CWMG_CTRL_SCDIS 0
`define CWMG_CTRL_RESET 16'h0000
`define CWMG_REFCNT_MAX 8'hff

`endif

// [include/cwmg_pkg.sv]
// Types and the self-write decode shared by the configuration word guard
`include "cwmg_consts.svh"

package cwmg_pkg;

    typedef enum logic [1:0] {
        LD_SYNC = 2'b00,
        LD_SETTLE = 2'b01,
        LD_CAPTURE = 2'b11,
        LD_RUN = 2'b10
    } cwmg_load_type;

    typedef enum logic [1:0] {
        PM_NONE = 2'b00,
        PM_LOW = 2'b01,
        PM_HIGH = 2'b11
    } cwmg_prog_type;

    typedef struct packed {
        logic lowVoltProgEn;
        logic scannerAvail;
        logic [1:0] selfWriteGuardSel;
        logic eepromReadLockN;
        logic progReadLockN;
    } cwmg_settings_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic eeprom;
        logic [14:0] addr;
    } cwmg_ext_req_type;

    function automatic logic cwmg_self_write_ok(input logic [1:0] sel, input logic [14:0] addr);
        logic ok;
        ok = 1'b1;
        // Only the program flash range is guarded; addresses above it are outside this block
        if (addr <= `CWMG_PROG_LAST) begin
            case (sel)
                `CWMG_SWG_OFF: ok = 1'b1;
                `CWMG_SWG_BOOT: ok = (addr > `CWMG_SWG_BOOT_LAST);
                `CWMG_SWG_HALF: ok = (addr > `CWMG_SWG_HALF_LAST);
                default: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

endpackage

// [logic/cwmg_self_write_guard.sv]
// Self-write range check for program flash
`timescale 1ns/1ps
`default_nettype none

module cwmg_self_write_guard (
    input wire logic [1:0] selfWriteGuardSel,
    input wire logic selfWriteValid,
    input wire logic [14:0] selfWriteAddr,
    output logic selfWriteGrant,
    output logic selfWriteRefuse
);
    import cwmg_pkg::*;

    logic inRange;

    // Read-lock bits play no part here
    assign inRange = cwmg_self_write_ok(selfWriteGuardSel, selfWriteAddr);
    assign selfWriteGrant = selfWriteValid & inRange;
    assign selfWriteRefuse = selfWriteValid & ~inRange;
endmodule

`default_nettype wire

// [logic/cwmg_ext_gate.sv]
// External access gate for program flash and data EEPROM
`timescale 1ns/1ps
`default_nettype none

module cwmg_ext_gate (
    input wire logic clk,
    input wire logic reset,
    input wire cwmg_pkg::cwmg_ext_req_type extReq,
    input wire logic progActive,
    input wire logic progReadLockN,
    input wire logic eepromReadLockN,
    input wire logic [13:0] memRdata,
    output logic extMemEnable,
    output logic extRefuse,
    output logic [13:0] extRdata,
    output logic extRvalid
);
    import cwmg_pkg::*;

    logic unlocked;

    // Each memory answers only to its own lock bit
    assign unlocked = extReq.eeprom ? eepromReadLockN : progReadLockN;
    assign extMemEnable = extReq.valid & progActive & unlocked;
    assign extRefuse = extReq.valid & ~(progActive & unlocked);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            extRvalid <= 1'b0;
        end else begin
            extRvalid <= extReq.valid & ~extReq.write;
        end
    end

    // Locked reads still answer, with zeros, so the tool never stalls
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            extRdata <= 14'h0000;
        end else if (extReq.valid & ~extReq.write) begin
            extRdata <= extMemEnable ? memRdata : 14'h0000;
        end
    end
endmodule

`default_nettype wire

// [logic/cwmg_guard.sv]
// Configuration word memory guard: loads protection words and enforces them
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cwmg_consts.svh"

module cwmg_guard (
    input wire logic clk,
    input wire logic reset,
    input wire logic [13:0] memConfigWordIn,
    input wire logic [13:0] codeProtectWordIn,
    input wire logic extResetPinEnIn,
    input wire logic highVoltDetect,
    input wire logic lowVoltKeyDetect,
    input wire logic cfgWriteValid,
    input wire logic cfgWriteSel,
    input wire logic [13:0] cfgWriteData,
    output logic nvmCfgWrite,
    output logic nvmCfgSel,
    output logic [13:0] nvmCfgData,
    output logic cfgWriteRefused,
    input wire cwmg_pkg::cwmg_ext_req_type extReq,
    input wire logic [13:0] memRdata,
    output logic extMemEnable,
    output logic [13:0] extRdata,
    output logic extRvalid,
    input wire logic selfWriteValid,
    input wire logic [14:0] selfWriteAddr,
    output logic selfWriteGrant,
    input wire logic cpuReadValid,
    output logic cpuReadEnable,
    output logic progModeLow,
    output logic progModeHigh,
    output logic extResetActive,
    output logic scannerEnable,
    output logic settingsValid,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata
);
    import cwmg_pkg::*;

    localparam int SyncW = 31;

    logic [SyncW-1:0] pinSync1;
    logic [SyncW-1:0] pinSync2;
    logic [13:0] memCfgPin;
    logic [13:0] codeProtPin;
    logic extResetPinEn;
    logic highVolt;
    logic lowVoltKey;

    cwmg_load_type loadState;
    cwmg_load_type next_loadState;
    cwmg_prog_type progState;
    cwmg_prog_type next_progState;

    cwmg_settings_type settings;
    logic [13:0] memCfgWord;
    logic [13:0] codeProtWord;

    logic extRefuse;
    logic selfWriteRefuse;
    logic lvEnClearTry;
    logic cfgAccept;

    logic [15:0] ctrl;
    logic extRefFlag;
    logic selfRefFlag;
    logic lvEnRefFlag;
    logic [7:0] refusedCount;
    logic statusClear;
    logic [15:0] statusWord;

    // Pin side: the two word inputs, the reset-pin enable and both voltage detects pass two flops before anything looks at them
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pinSync1 <= '0;
            pinSync2 <= '0;
        end else begin
            pinSync1 <= {memConfigWordIn, codeProtectWordIn, extResetPinEnIn, highVoltDetect, lowVoltKeyDetect};
            pinSync2 <= pinSync1;
        end
    end

    assign memCfgPin = pinSync2[30:17];
    assign codeProtPin = pinSync2[16:3];
    assign extResetPinEn = pinSync2[2];
    assign highVolt = pinSync2[1];
    assign lowVoltKey = pinSync2[0];

    // Load sequence: let the synchroniser fill, then capture the words once
    always_comb begin
        next_loadState = loadState;
        case (loadState)
            LD_SYNC: next_loadState = LD_SETTLE;
            LD_SETTLE: next_loadState = LD_CAPTURE;
            LD_CAPTURE: next_loadState = LD_RUN;
            LD_RUN: next_loadState = LD_RUN;
            default: next_loadState = LD_SYNC;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            loadState <= LD_SYNC;
        end else begin
            loadState <= next_loadState;
        end
    end

    // Until capture the words look blank: all ones, which is the unprotected state,
    // but nothing is granted to the outside before settingsValid anyway
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            memCfgWord <= `CWMG_WORD_BLANK;
            codeProtWord <= `CWMG_WORD_BLANK;
        end else if (loadState == LD_CAPTURE) begin
            memCfgWord <= memCfgPin | `CWMG_MEMCFG_UNIMPL;
            codeProtWord <= codeProtPin | `CWMG_CODEPROT_UNIMPL;
        end
    end

    assign settings.lowVoltProgEn = memCfgWord[`CWMG_LVE_BIT];
    assign settings.scannerAvail = memCfgWord[`CWMG_SCAV_BIT];
    assign settings.selfWriteGuardSel = memCfgWord[`CWMG_SWG_LSB+1:`CWMG_SWG_LSB];
    assign settings.eepromReadLockN = codeProtWord[`CWMG_EEL_BIT];
    assign settings.progReadLockN = codeProtWord[`CWMG_PRL_BIT];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            settingsValid <= 1'b0;
        end else begin
            settingsValid <= (loadState == LD_CAPTURE) | settingsValid;
        end
    end

    // Programming entry. From PM_NONE high voltage wins over the low-voltage key and needs no enable; in PM_LOW it waits for the key to drop.
    always_comb begin
        next_progState = progState;
        case (progState)
            PM_NONE: begin
                if (highVolt) begin
                    next_progState = PM_HIGH;
                end else if (lowVoltKey & settings.lowVoltProgEn) begin
                    next_progState = PM_LOW;
                end
            end
            PM_LOW: begin
                if (~lowVoltKey) begin
                    next_progState = PM_NONE;
                end
            end
            PM_HIGH: begin
                if (~highVolt) begin
                    next_progState = PM_NONE;
                end
            end
            default: next_progState = PM_NONE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            progState <= PM_NONE;
        end else if (settingsValid) begin
            progState <= next_progState;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            progModeLow <= 1'b0;
            progModeHigh <= 1'b0;
        end else begin
            progModeLow <= settingsValid & (next_progState == PM_LOW);
            progModeHigh <= settingsValid & (next_progState == PM_HIGH);
        end
    end

    // With low-voltage entry enabled the shared pin is a reset whatever the enable says
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            extResetActive <= 1'b1;
        end else begin
            extResetActive <= settings.lowVoltProgEn | extResetPinEn;
        end
    end

    // Configuration word writes from the programming tool. New words go to NVM only;
    // the live settings stay frozen until the next reset.
    assign lvEnClearTry = cfgWriteValid & ~cfgWriteSel & ~cfgWriteData[`CWMG_LVE_BIT] & (progState == PM_LOW);
    assign cfgAccept = cfgWriteValid & (progState != PM_NONE) & ~lvEnClearTry;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nvmCfgWrite <= 1'b0;
            cfgWriteRefused <= 1'b0;
        end else begin
            nvmCfgWrite <= cfgAccept;
            cfgWriteRefused <= cfgWriteValid & ~cfgAccept;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nvmCfgSel <= 1'b0;
            nvmCfgData <= `CWMG_WORD_BLANK;
        end else if (cfgAccept) begin
            nvmCfgSel <= cfgWriteSel;
            nvmCfgData <= cfgWriteData;
        end
    end

    cwmg_ext_gate extGate (
        .clk(clk),
        .reset(reset),
        .extReq(extReq),
        .progActive(progState != PM_NONE),
        .progReadLockN(settings.progReadLockN),
        .eepromReadLockN(settings.eepromReadLockN),
        .memRdata(memRdata),
        .extMemEnable(extMemEnable),
        .extRefuse(extRefuse),
        .extRdata(extRdata),
        .extRvalid(extRvalid)
    );

    logic rawSelfGrant;

    cwmg_self_write_guard selfGuard (
        .selfWriteGuardSel(settings.selfWriteGuardSel),
        .selfWriteValid(selfWriteValid & settingsValid),
        .selfWriteAddr(selfWriteAddr),
        .selfWriteGrant(rawSelfGrant),
        .selfWriteRefuse(selfWriteRefuse)
    );

    assign selfWriteGrant = rawSelfGrant;

    // The CPU fetch path ignores both lock bits
    assign cpuReadEnable = cpuReadValid;

    // Scanner is usable only when the word makes it available
    assign scannerEnable = settingsValid & settings.scannerAvail & ~ctrl[`CWMG_CTRL_SCDIS];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl <= `CWMG_CTRL_RESET;
        end else if (regWrite && regAddr == `CWMG_REG_CTRL) begin
            ctrl <= {15'h0000, regWdata[`CWMG_CTRL_SCDIS]};
        end
    end

    // Sticky refusal flags: write one to clear, a new event in the same cycle wins
    assign statusClear = regWrite && regAddr == `CWMG_REG_STATUS;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            extRefFlag <= 1'b0;
        end else if (extRefuse) begin
            extRefFlag <= 1'b1;
        end else if (statusClear & regWdata[`CWMG_ST_EXT_REF]) begin
            extRefFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            selfRefFlag <= 1'b0;
        end else if (selfWriteRefuse) begin
            selfRefFlag <= 1'b1;
        end else if (statusClear & regWdata[`CWMG_ST_SELF_REF]) begin
            selfRefFlag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lvEnRefFlag <= 1'b0;
        end else if (lvEnClearTry) begin
            lvEnRefFlag <= 1'b1;
        end else if (statusClear & regWdata[`CWMG_ST_LVE_REF]) begin
            lvEnRefFlag <= 1'b0;
        end
    end

    // Saturating count of cycles with an external, self-write or enable-clear refusal; a write clears it unless one comes in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            refusedCount <= 8'h00;
        end else if (extRefuse | selfWriteRefuse | lvEnClearTry) begin
            if (refusedCount != `CWMG_REFCNT_MAX) begin
                refusedCount <= refusedCount + 8'h01;
            end
        end else if (regWrite && regAddr == `CWMG_REG_REFCNT) begin
            refusedCount <= 8'h00;
        end
    end

    always_comb begin
        statusWord = 16'h0000;
        statusWord[`CWMG_ST_LOADED] = settingsValid;
        statusWord[`CWMG_ST_PROG_LOW] = (progState == PM_LOW);
        statusWord[`CWMG_ST_PROG_HIGH] = (progState == PM_HIGH);
        statusWord[`CWMG_ST_EXT_REF] = extRefFlag;
        statusWord[`CWMG_ST_SELF_REF] = selfRefFlag;
        statusWord[`CWMG_ST_LVE_REF] = lvEnRefFlag;
    end

    // Read data stands in the cycle after the strobe only; unmapped reads give zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            regRdata <= 16'h0000;
        end else if (regRead) begin
            case (regAddr)
                `CWMG_REG_MEMCFG: regRdata <= {2'h0, memCfgWord};
                `CWMG_REG_CODEPROT: regRdata <= {2'h0, codeProtWord};
                `CWMG_REG_STATUS: regRdata <= statusWord;
                `CWMG_REG_CTRL: regRdata <= ctrl;
                `CWMG_REG_REFCNT: regRdata <= {8'h00, refusedCount};
                default: regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end
endmodule

`default_nettype wire

// [test/cwmg_guard_assertions.sv]
// Checker for the configuration word guard, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module cwmg_guard_assertions (
    input wire logic clk,
    input wire logic reset,
    input wire logic [13:0] memConfigWordIn,
    input wire logic [13:0] codeProtectWordIn,
    input wire logic cfgWriteValid,
    input wire logic cfgWriteSel,
    input wire logic [13:0] cfgWriteData,
    input wire logic nvmCfgWrite,
    input wire logic cfgWriteRefused,
    input wire cwmg_pkg::cwmg_ext_req_type extReq,
    input wire logic [13:0] memRdata,
    input wire logic extMemEnable,
    input wire logic [13:0] extRdata,
    input wire logic extRvalid,
    input wire logic selfWriteValid,
    input wire logic [14:0] selfWriteAddr,
    input wire logic selfWriteGrant,
    input wire logic cpuReadValid,
    input wire logic cpuReadEnable,
    input wire logic progModeLow,
    input wire logic progModeHigh,
    input wire logic highVoltDetect,
    input wire logic extResetActive,
    input wire logic scannerEnable,
    input wire logic settingsValid,
    input wire logic [3:0] regAddr,
    input wire logic regRead,
    input wire logic [15:0] regRdata
);
    import cwmg_pkg::*;
    logic haveCfg;
    logic [13:0] cMem;
    logic [13:0] cCode;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Pins are held steady by the bench until capture, so a running copy matches the loaded words
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            haveCfg <= 1'b0;
        end else begin
            haveCfg <= settingsValid;
            if (!settingsValid) begin
                cMem <= memConfigWordIn;
                cCode <= codeProtectWordIn;
            end
        end
    end
    function automatic logic selfOk(input logic [1:0] s, input logic [14:0] a);
        if (a > 15'h3fff) return 1'b1;
        return s == 2'h3 || (s == 2'h2 && a >= 15'h0200) || (s == 2'h1 && a >= 15'h2000);
    endfunction
    AST_CPU_READ: assert property (cpuReadValid |-> cpuReadEnable)
        else $error("cpu read not enabled");
    AST_SELF_GUARD: assert property (haveCfg && selfWriteValid |-> selfWriteGrant == selfOk(cMem[1:0], selfWriteAddr))
        else $error("self write grant wrong");
    AST_PROG_LOCK: assert property (haveCfg && extReq.valid && !extReq.eeprom && !cCode[0] |-> !extMemEnable)
        else $error("locked program access passed");
    AST_EE_LOCK: assert property (haveCfg && extReq.valid && extReq.eeprom && !cCode[1] |-> !extMemEnable)
        else $error("locked eeprom access passed");
    AST_ZERO_DATA: assert property (extReq.valid && !extReq.write && !extMemEnable |=> extRvalid && extRdata == 14'h0)
        else $error("refused read not zero");
    AST_OPEN_DATA: assert property (extReq.valid && !extReq.write && extMemEnable |=> extRdata == $past(memRdata))
        else $error("open read data wrong");
    AST_LVE_PIN: assert property (haveCfg && cMem[13] |-> extResetActive)
        else $error("shared pin not reset");
    AST_LOW_NEEDS_LVP: assert property (haveCfg && progModeLow |-> cMem[13])
        else $error("low entry without enable");
    AST_LVE_HOLD: assert property (cfgWriteValid && !cfgWriteSel && !cfgWriteData[13] && progModeLow
        |=> cfgWriteRefused && !nvmCfgWrite)
        else $error("enable clear accepted");
    AST_HV_ENTRY: assert property (haveCfg && !progModeLow && highVoltDetect [*5] |-> ##[0:3] progModeHigh)
        else $error("high voltage entry missed");
    AST_SCAN_OFF: assert property (haveCfg && !cMem[12] |-> !scannerEnable)
        else $error("scanner on while unavailable");
    AST_FROZEN: assert property (haveCfg && regRead && regAddr == 4'h0 |=> regRdata == {2'h0, cMem | 14'h0ffc})
        else $error("memory word read wrong");
endmodule
bind cwmg_guard cwmg_guard_assertions u_chk (.clk, .reset, .memConfigWordIn, .codeProtectWordIn, .cfgWriteValid,
    .cfgWriteSel, .cfgWriteData, .nvmCfgWrite, .cfgWriteRefused, .extReq, .memRdata, .extMemEnable, .extRdata,
    .extRvalid, .selfWriteValid, .selfWriteAddr, .selfWriteGrant, .cpuReadValid, .cpuReadEnable, .progModeLow,
    .progModeHigh, .highVoltDetect, .extResetActive, .scannerEnable, .settingsValid, .regAddr, .regRead, .regRdata);
`default_nettype wire

// [test/cwmg_tool_model.sv]
// Programming tool model on the external side of the guard
`timescale 1ns/1ps
`default_nettype none
module cwmg_tool_model (
    input wire logic clk,
    output var cwmg_pkg::cwmg_ext_req_type extReq,
    output var logic highVoltDetect,
    output var logic lowVoltKeyDetect,
    output var logic cfgWriteValid,
    output var logic cfgWriteSel,
    output var logic [13:0] cfgWriteData
);
    import cwmg_pkg::*;
    initial begin
        extReq = '0;
        highVoltDetect = 1'b0;
        lowVoltKeyDetect = 1'b0;
        cfgWriteValid = 1'b0;
        cfgWriteSel = 1'b0;
        cfgWriteData = 14'h0;
    end
    // Released fields turn over so a stale request never looks valid by accident
    task automatic put(input logic v, input logic w, input logic e, input logic [14:0] a);
        @(posedge clk);
        if (v) extReq <= cwmg_ext_req_type'({v, w, e, a});
        else extReq <= cwmg_ext_req_type'({1'b0, ~extReq[16:0]});
    endtask
    task automatic power(input logic hv, input logic key);
        @(posedge clk);
        highVoltDetect <= hv;
        lowVoltKeyDetect <= key;
    endtask
    task automatic cfg(input logic v, input logic s, input logic [13:0] d);
        @(posedge clk);
        cfgWriteValid <= v;
        cfgWriteSel <= v ? s : ~cfgWriteSel;
        cfgWriteData <= v ? d : ~cfgWriteData;
    endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the configuration word memory guard
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cwmg_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [13:0] memConfigWordIn, codeProtectWordIn, memRdata, nvmCfgData, extRdata, cfgWriteData;
    logic extResetPinEnIn, selfWriteValid, cpuReadValid, regWrite, regRead, lve, scan, pl, el;
    logic nvmCfgWrite, nvmCfgSel, cfgWriteRefused, extMemEnable, extRvalid, selfWriteGrant, cpuReadEnable;
    logic progModeLow, progModeHigh, extResetActive, scannerEnable, settingsValid;
    logic highVoltDetect, lowVoltKeyDetect, cfgWriteValid, cfgWriteSel;
    logic [14:0] selfWriteAddr;
    logic [3:0] regAddr;
    logic [15:0] regWdata, regRdata;
    logic [1:0] w;
    cwmg_ext_req_type extReq;
    logic [14:0] pts[7] = '{15'h0000, 15'h01ff, 15'h0200, 15'h1fff, 15'h2000, 15'h3fff, 15'h4000};
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    always #20 clk = ~clk;
    cwmg_tool_model u_tool (.clk, .extReq, .highVoltDetect, .lowVoltKeyDetect, .cfgWriteValid, .cfgWriteSel,
        .cfgWriteData);
    cwmg_guard u_dut (.clk, .reset, .memConfigWordIn, .codeProtectWordIn, .extResetPinEnIn, .highVoltDetect,
        .lowVoltKeyDetect, .cfgWriteValid, .cfgWriteSel, .cfgWriteData, .nvmCfgWrite, .nvmCfgSel, .nvmCfgData,
        .cfgWriteRefused, .extReq, .memRdata, .extMemEnable, .extRdata, .extRvalid, .selfWriteValid,
        .selfWriteAddr, .selfWriteGrant, .cpuReadValid, .cpuReadEnable, .progModeLow, .progModeHigh,
        .extResetActive, .scannerEnable, .settingsValid, .regAddr, .regWdata, .regWrite, .regRead, .regRdata);
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Run is a few hundred cycles; far beyond that something hangs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            print_verdict;
        end
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic expSelf(input logic [1:0] s, input logic [14:0] a);
        if (a > 15'h3fff) return 1'b1;
        return s == 2'h3 || (s == 2'h2 && a >= 15'h0200) || (s == 2'h1 && a >= 15'h2000);
    endfunction
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        chk("regRdata", e, regRdata);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic ext(input logic ee, input logic wt, input logic [14:0] a, input logic ok);
        logic [13:0] d;
        u_tool.put(1'b1, wt, ee, a);
        memRdata <= 14'($urandom);
        @(negedge clk);
        d = memRdata;
        chk("extMemEnable", ok, extMemEnable);
        u_tool.put(1'b0, 1'b0, 1'b0, 15'h0);
        @(negedge clk);
        if (!wt) chk("extRdata", {1'b1, ok ? d : 14'h0}, {extRvalid, extRdata});
    endtask
    task automatic cfgW(input logic s, input logic [13:0] d, input logic acc);
        u_tool.cfg(1'b1, s, d);
        u_tool.cfg(1'b0, 1'b0, 14'h0);
        @(negedge clk);
        chk("cfgWriteResult", {acc, !acc}, {nvmCfgWrite, cfgWriteRefused});
        if (acc) chk("nvmCfgData", {1'b0, s, d}, {1'b0, nvmCfgSel, nvmCfgData});
    endtask
    initial begin
        {regWrite, regRead, selfWriteValid, cpuReadValid, extResetPinEnIn} = '0;
        {regAddr, regWdata, selfWriteAddr, memRdata} = '0;
        memConfigWordIn = 14'h3fff;
        codeProtectWordIn = 14'h3fff;
        void'($urandom(83));
        for (int k = 0; k < 4; k++) begin
            w = 2'(k);
            {el, pl} = w;
            lve = w[0] ^ w[1];
            scan = w[1];
            @(posedge clk);
            memConfigWordIn <= {lve, scan, 10'($urandom), w};
            codeProtectWordIn <= {12'($urandom), el, pl};
            extResetPinEnIn <= 1'($urandom);
            reset <= 1'b1;
            repeat (3) @(posedge clk);
            reset <= 1'b0;
            for (int j = 0; j < 8 && settingsValid !== 1'b1; j++) @(posedge clk);
            @(negedge clk);
            chk("settingsValid", 1'b1, settingsValid);
            rd(4'h0, {2'h0, lve, scan, 10'h3ff, w});
            rd(4'h1, {2'h0, 12'hfff, el, pl});
            rd(4'hf, 16'h0);
            chk("extResetActive", lve | extResetPinEnIn, extResetActive);
            chk("scannerEnable", scan, scannerEnable);
            wr(4'h3, 16'h0001);
            wr(4'h0, 16'h0000);
            @(negedge clk);
            chk("scannerEnable", 1'b0, scannerEnable);
            wr(4'h3, 16'h0000);
            for (int i = 0; i < 11; i++) begin
                @(posedge clk);
                selfWriteValid <= 1'b1;
                cpuReadValid <= i[0];
                selfWriteAddr <= i < 7 ? pts[i] : 15'($urandom);
                @(negedge clk);
                chk("selfWriteGrant", expSelf(w, selfWriteAddr), selfWriteGrant);
                chk("cpuReadEnable", i[0], cpuReadEnable);
            end
            @(posedge clk);
            selfWriteValid <= 1'b0;
            ext(1'b0, 1'b0, 15'h0100, 1'b0);
            u_tool.power(1'b0, 1'b1);
            for (int j = 0; j < 10 && progModeLow !== lve; j++) @(posedge clk);
            repeat (4) @(negedge clk);
            chk("progModeLow", lve, progModeLow);
            if (lve) cfgW(1'b0, 14'h1fff, 1'b0);
            if (lve) cfgW(1'b0, 14'h3fff, 1'b1);
            u_tool.power(1'b0, 1'b0);
            for (int j = 0; j < 10 && progModeLow !== 1'b0; j++) @(posedge clk);
            u_tool.power(1'b1, 1'b0);
            for (int j = 0; j < 10 && progModeHigh !== 1'b1; j++) @(posedge clk);
            chk("progModeHigh", 1'b1, progModeHigh);
            for (int i = 0; i < 6; i++) ext(i[0], i[1], 15'($urandom) & 15'h3fff, i[0] ? el : pl);
            cfgW(1'b0, 14'h1fff, 1'b1);
            u_tool.power(1'b0, 1'b0);
            memConfigWordIn <= ~memConfigWordIn;
            codeProtectWordIn <= ~codeProtectWordIn;
            repeat (8) @(posedge clk);
            rd(4'h0, {2'h0, lve, scan, 10'h3ff, w});
            rd(4'h1, {2'h0, 12'hfff, el, pl});
            rd(4'h2, {10'h0, lve, w != 2'h3, 4'h9});
            $display("config %0d done", k);
        end
        print_verdict;
    end
endmodule
`default_nettype wire
